// File: core/civ_regs.vh
// Offsets, fields, reset values and vector codes of the vector generator.
`ifndef CIV_REGS_VH
`define CIV_REGS_VH
`define CIV_ADDR_W 8
`define CIV_CTRL_OFS 8'h00
`define CIV_SHORT_OFS 8'h04
`define CIV_MIN_OFS 8'h08
`define CIV_MAX_OFS 8'h0C
`define CIV_THRESH_OFS 8'h10
`define CIV_STATUS_OFS 8'h14
`define CIV_COUNT_OFS 8'h18
`define CIV_LAST_OFS 8'h1C
`define CIV_CTRL_RST 32'h0000_0000
`define CIV_SHORT_RST 16'h0004
`define CIV_MIN_RST 16'h0004
`define CIV_MAX_RST 16'h0600
`define CIV_THRESH_RST 8'h01
`define CIV_CTRL_EN_BIT 0
`define CIV_CTRL_RXQ_LSB 4
`define CIV_CTRL_TXQ_LSB 8
`define CIV_STAT_BUSY_BIT 16
`define CIV_RESP_OKAY 2'h0
`define CIV_RESP_SLVERR 2'h2
`define CIV_VEC_TOP 1'h1
`define CIV_CODE_CHANNEL_NUMBER 2'h1
`define CIV_SUB_RX1 2'h0
`define CIV_SUB_TX1 2'h2
`define CIV_SUB_RX2 2'h1
`define CIV_FLAG_OVF 15
`define CIV_FLAG_SHORT 14
`define CIV_FLAG_TOFLAG 13
`define CIV_FLAG_TOIDLE 12
`define CIV_FLAG_SMALLDROP 11
`define CIV_FLAG_UNDERRUN 15
`define CIV_FLAG_TXEND 14
`define CIV_FLAG_HOSTREQ 15
`define CIV_FLAG_ABORT 14
`define CIV_FLAG_RXEND 13
`define CIV_FLAG_HELDABORT 12
`define CIV_FLAG_MAXLEN 11
`define CIV_FLAG_RXOVF 10
`define CIV_FLAG_CRC 9
`define CIV_FLAG_BADLEN 8
`define CIV_FILL_FLAG 8'h7E
`define CIV_FILL_IDLE 8'hFF
`define CIV_NSLOT 9
`endif

// File: core/civ_fill_detect.v
// Interframe fill watcher that reports changes between idle bytes and flag bytes.
`include "civ_regs.vh"
module civ_fill_detect (
  input wire aclk,
  input wire aresetn,
  input wire fill_valid,
  input wire [7:0] fill_byte,
  output reg to_flag,
  output reg to_idle
);
  localparam ST_NONE = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_FLAG = 2'h2;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  // Other bytes leave the remembered fill untouched, so noise cannot fake a change.
  always @* begin
    state_next = state_reg;
    if (fill_valid && fill_byte == `CIV_FILL_FLAG) begin
      state_next = ST_FLAG;
    end else if (fill_valid && fill_byte == `CIV_FILL_IDLE) begin
      state_next = ST_IDLE;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_NONE;
      to_flag <= 1'b0;
      to_idle <= 1'b0;
    end else begin
      state_reg <= state_next;
      to_flag <= (state_reg == ST_IDLE) && (state_next == ST_FLAG);
      to_idle <= (state_reg == ST_FLAG) && (state_next == ST_IDLE);
    end
  end
endmodule

// File: core/civ_len_classify.v
// Frame length checks: short frames, dropped small frames with a threshold count, oversize frames.
`include "civ_regs.vh"
module civ_len_classify #(
  parameter LEN_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire frame_valid,
  input wire [LEN_W-1:0] frame_len,
  input wire [LEN_W-1:0] short_len,
  input wire [LEN_W-1:0] min_len,
  input wire [LEN_W-1:0] max_len,
  input wire [7:0] drop_thresh,
  output wire is_short,
  output wire is_small,
  output wire is_oversize,
  output wire drops_reached
);
  reg [7:0] drop_cnt_reg;
  reg [7:0] drop_cnt_next;
  wire [7:0] cnt_inc;
  assign is_short = frame_valid && (frame_len <= short_len);
  assign is_small = frame_valid && (frame_len < min_len);
  assign is_oversize = frame_valid && (frame_len > max_len);
  assign cnt_inc = drop_cnt_reg + 8'h01;
  // A threshold of zero is treated as one so the flag cannot stay silent forever.
  assign drops_reached = is_small && (cnt_inc >= drop_thresh);
  always @* begin
    drop_cnt_next = drop_cnt_reg;
    if (drops_reached) begin
      drop_cnt_next = 8'h00;
    end else if (is_small) begin
      drop_cnt_next = cnt_inc;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      drop_cnt_reg <= 8'h00;
    end else begin
      drop_cnt_reg <= drop_cnt_next;
    end
  end
endmodule

// File: core/civ_vector_gen.v
// Channel interrupt vector generator with AXI4-Lite configuration and a queue write port.
`include "civ_regs.vh"
// Functional notes
// - Subtype I vectors carry no descriptor tag.
// - Subtype II vectors belong to a descriptor.
// - Receive II: tag bits 21:16, 23:22 zero.
// - Receive I header, queue, channel, zero gaps.
// - Transmit I: code 10, underrun, frame end.
// - Flag overflow when receive buffer discards data.
// - Flag short frames by length condition.
// - Flag fill change from idle to flag.
// - Flag fill change from flag to idle.
// - Flag after N small frames dropped.
// - Flag underrun and abort packet in progress.
// - Flag each transmitted frame end.
// - Host request vector when descriptor finishes.
// - Hold abort on first held discard.
// - Later held discards on the same channel set abort too.
// - Flag frames longer than maximum length.
module civ_vector_gen #(
  parameter LEN_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_discard,
  input wire [7:0] rx_discard_channel_number,
  input wire fill_valid,
  input wire [7:0] fill_byte,
  input wire [7:0] fill_channel_number,
  input wire rx_frame_done,
  input wire [7:0] rx_frame_channel_number,
  input wire [5:0] rx_frame_tag,
  input wire [LEN_W-1:0] rx_frame_len,
  input wire rx_frame_host_req,
  input wire rx_frame_abort,
  input wire rx_frame_dma_ovf,
  input wire rx_frame_crc_err,
  input wire rx_frame_bad_len,
  input wire rx_desc_done,
  input wire [7:0] rx_desc_channel_number,
  input wire [5:0] rx_desc_tag,
  input wire rx_hold_discard,
  input wire [7:0] rx_hold_channel_number,
  input wire [5:0] rx_hold_tag,
  input wire tx_underrun,
  input wire tx_in_packet,
  input wire tx_frame_sent,
  input wire [7:0] tx_channel_number,
  output reg tx_abort_req,
  output reg rx_small_drop,
  output reg qw_valid,
  input wire qw_ready,
  output reg [2:0] qw_queue,
  output reg [31:0] qw_data
);
  localparam NS = `CIV_NSLOT;
  localparam S_OVF = 0;
  localparam S_SHORT = 1;
  localparam S_TOFLAG = 2;
  localparam S_TOIDLE = 3;
  localparam S_SMALL = 4;
  localparam S_UNDER = 5;
  localparam S_TXEND = 6;
  localparam S_RXII = 7;
  localparam S_HOLD = 8;

  reg [31:0] ctrl_reg;
  reg [LEN_W-1:0] short_reg;
  reg [LEN_W-1:0] min_reg;
  reg [LEN_W-1:0] max_reg;
  reg [7:0] thresh_reg;
  reg [31:0] count_reg;
  reg [31:0] last_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [NS-1:0] pend_reg;
  reg [32*NS-1:0] word_reg;
  reg held_seen_reg;
  reg [7:0] held_channel_number_reg;
  reg [NS-1:0] set_vec;
  reg [32*NS-1:0] set_word;
  reg [NS-1:0] grant;
  reg [31:0] rd_val;
  reg rd_ok;
  reg [31:0] wr_mask;
  reg [7:0] rx2_flags;
  reg [7:0] hold_flags;
  reg found;
  integer k;

  wire enable;
  wire [2:0] rx_q;
  wire [2:0] tx_q;
  wire to_flag;
  wire to_idle;
  wire is_short;
  wire is_small;
  wire is_oversize;
  wire drops_reached;
  wire wr_fire;
  wire load_out;

  assign enable = ctrl_reg[`CIV_CTRL_EN_BIT];
  assign rx_q = ctrl_reg[`CIV_CTRL_RXQ_LSB+2:`CIV_CTRL_RXQ_LSB];
  assign tx_q = ctrl_reg[`CIV_CTRL_TXQ_LSB+2:`CIV_CTRL_TXQ_LSB];

  civ_fill_detect u_fill (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill_valid(fill_valid),
    .fill_byte(fill_byte),
    .to_flag(to_flag),
    .to_idle(to_idle)
  );

  civ_len_classify #(
    .LEN_W(LEN_W)
  ) u_len (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_valid(rx_frame_done),
    .frame_len(rx_frame_len),
    .short_len(short_reg),
    .min_len(min_reg),
    .max_len(max_reg),
    .drop_thresh(thresh_reg),
    .is_short(is_short),
    .is_small(is_small),
    .is_oversize(is_oversize),
    .drops_reached(drops_reached)
  );

  // Header, subtype, queue, middle byte, flags, channel.
  function [31:0] mk_vec;
    input [1:0] sub;
    input [2:0] queue;
    input [7:0] mid;
    input [7:0] flags;
    input [7:0] channel_number;
    begin
      mk_vec = {`CIV_VEC_TOP, `CIV_CODE_CHANNEL_NUMBER, sub, queue, mid, flags, channel_number};
    end
  endfunction

  // The fill watcher reports one cycle late, so its channel is latched to match.
  reg [7:0] fill_channel_number_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      fill_channel_number_reg <= 8'h00;
    end else if (fill_valid) begin
      fill_channel_number_reg <= fill_channel_number;
    end
  end

  always @* begin
    set_vec = {NS{1'b0}};
    set_word = {32*NS{1'b0}};
    rx2_flags = 8'h00;
    hold_flags = 8'h00;
    rx2_flags[`CIV_FLAG_HOSTREQ-8] = rx_frame_host_req;
    rx2_flags[`CIV_FLAG_ABORT-8] = rx_frame_abort;
    rx2_flags[`CIV_FLAG_RXEND-8] = 1'b1;
    rx2_flags[`CIV_FLAG_MAXLEN-8] = is_oversize;
    rx2_flags[`CIV_FLAG_RXOVF-8] = rx_frame_dma_ovf;
    rx2_flags[`CIV_FLAG_CRC-8] = rx_frame_crc_err;
    rx2_flags[`CIV_FLAG_BADLEN-8] = rx_frame_bad_len;
    hold_flags[`CIV_FLAG_HELDABORT-8] = 1'b1;
    hold_flags[`CIV_FLAG_ABORT-8] = held_seen_reg && (held_channel_number_reg == rx_hold_channel_number);
    if (enable) begin
      // Subtype I words keep the middle byte zero: no descriptor is referenced.
      set_vec[S_OVF] = rx_discard;
      set_word[32*S_OVF +: 32] = mk_vec(`CIV_SUB_RX1, rx_q, 8'h00, 8'h80, rx_discard_channel_number);
      set_vec[S_SHORT] = is_short && !is_small;
      set_word[32*S_SHORT +: 32] = mk_vec(`CIV_SUB_RX1, rx_q, 8'h00, 8'h40, rx_frame_channel_number);
      set_vec[S_TOFLAG] = to_flag;
      set_word[32*S_TOFLAG +: 32] = mk_vec(`CIV_SUB_RX1, rx_q, 8'h00, 8'h20, fill_channel_number_reg);
      set_vec[S_TOIDLE] = to_idle;
      set_word[32*S_TOIDLE +: 32] = mk_vec(`CIV_SUB_RX1, rx_q, 8'h00, 8'h10, fill_channel_number_reg);
      set_vec[S_SMALL] = drops_reached;
      set_word[32*S_SMALL +: 32] = mk_vec(`CIV_SUB_RX1, rx_q, 8'h00, 8'h08, rx_frame_channel_number);
      set_vec[S_UNDER] = tx_underrun;
      set_word[32*S_UNDER +: 32] = mk_vec(`CIV_SUB_TX1, tx_q, 8'h00, 8'h80, tx_channel_number);
      set_vec[S_TXEND] = tx_frame_sent;
      set_word[32*S_TXEND +: 32] = mk_vec(`CIV_SUB_TX1, tx_q, 8'h00, 8'h40, tx_channel_number);
      // Frame end beats descriptor completion in the shared slot.
      if (rx_frame_done && !is_small) begin
        set_vec[S_RXII] = 1'b1;
        set_word[32*S_RXII +: 32] = mk_vec(`CIV_SUB_RX2, rx_q, {2'h0, rx_frame_tag}, rx2_flags, rx_frame_channel_number);
      end else if (rx_desc_done) begin
        set_vec[S_RXII] = 1'b1;
        set_word[32*S_RXII +: 32] = mk_vec(`CIV_SUB_RX2, rx_q, {2'h0, rx_desc_tag}, 8'h80, rx_desc_channel_number);
      end
      set_vec[S_HOLD] = rx_hold_discard;
      set_word[32*S_HOLD +: 32] = mk_vec(`CIV_SUB_RX2, rx_q, {2'h0, rx_hold_tag}, hold_flags, rx_hold_channel_number);
    end
  end

  // Fixed priority: lowest slot first. A slot hit by a new event keeps the newer word.
  always @* begin
    grant = {NS{1'b0}};
    found = 1'b0;
    for (k = 0; k < NS; k = k + 1) begin
      if (pend_reg[k] && !found) begin
        grant[k] = 1'b1;
        found = 1'b1;
      end
    end
  end

  assign load_out = found && (!qw_valid || qw_ready);

  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_slot
      always @(posedge aclk) begin
        if (!aresetn) begin
          pend_reg[g] <= 1'b0;
          word_reg[32*g +: 32] <= 32'h0000_0000;
        end else if (set_vec[g]) begin
          pend_reg[g] <= 1'b1;
          word_reg[32*g +: 32] <= set_word[32*g +: 32];
        end else if (load_out && grant[g]) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Output stage holds the word steady until the queue writer accepts it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      qw_valid <= 1'b0;
      qw_data <= 32'h0000_0000;
      qw_queue <= 3'h0;
      count_reg <= 32'h0000_0000;
      last_reg <= 32'h0000_0000;
    end else begin
      if (qw_valid && qw_ready) begin
        count_reg <= count_reg + 32'h0000_0001;
        last_reg <= qw_data;
      end
      if (load_out) begin
        qw_valid <= 1'b1;
        for (k = 0; k < NS; k = k + 1) begin
          if (grant[k]) begin
            qw_data <= word_reg[32*k +: 32];
            qw_queue <= word_reg[32*k+24 +: 3];
          end
        end
      end else if (qw_ready) begin
        qw_valid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_abort_req <= 1'b0;
      rx_small_drop <= 1'b0;
      held_seen_reg <= 1'b0;
      held_channel_number_reg <= 8'h00;
    end else begin
      tx_abort_req <= tx_underrun && tx_in_packet;
      rx_small_drop <= is_small;
      // Any non-held frame or completion ends a run of held discards.
      if (rx_hold_discard) begin
        held_seen_reg <= 1'b1;
        held_channel_number_reg <= rx_hold_channel_number;
      end else if (rx_frame_done || rx_desc_done) begin
        held_seen_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always @* begin
    wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIV_RESP_OKAY;
      ctrl_reg <= `CIV_CTRL_RST;
      short_reg <= `CIV_SHORT_RST;
      min_reg <= `CIV_MIN_RST;
      max_reg <= `CIV_MAX_RST;
      thresh_reg <= `CIV_THRESH_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CIV_RESP_OKAY;
        case (awaddr_reg[7:2])
          `CIV_CTRL_OFS >> 2: begin
            ctrl_reg <= ((ctrl_reg & ~wr_mask) | (wdata_reg & wr_mask)) & 32'h0000_0771;
          end
          `CIV_SHORT_OFS >> 2: begin
            short_reg <= (short_reg & ~wr_mask[LEN_W-1:0]) | (wdata_reg[LEN_W-1:0] & wr_mask[LEN_W-1:0]);
          end
          `CIV_MIN_OFS >> 2: begin
            min_reg <= (min_reg & ~wr_mask[LEN_W-1:0]) | (wdata_reg[LEN_W-1:0] & wr_mask[LEN_W-1:0]);
          end
          `CIV_MAX_OFS >> 2: begin
            max_reg <= (max_reg & ~wr_mask[LEN_W-1:0]) | (wdata_reg[LEN_W-1:0] & wr_mask[LEN_W-1:0]);
          end
          `CIV_THRESH_OFS >> 2: begin
            if (wstrb_reg[0]) begin
              thresh_reg <= wdata_reg[7:0];
            end
          end
          `CIV_STATUS_OFS >> 2, `CIV_COUNT_OFS >> 2, `CIV_LAST_OFS >> 2: begin
            s_axi_bresp <= `CIV_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `CIV_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `CIV_CTRL_OFS >> 2: rd_val = ctrl_reg;
      `CIV_SHORT_OFS >> 2: rd_val[LEN_W-1:0] = short_reg;
      `CIV_MIN_OFS >> 2: rd_val[LEN_W-1:0] = min_reg;
      `CIV_MAX_OFS >> 2: rd_val[LEN_W-1:0] = max_reg;
      `CIV_THRESH_OFS >> 2: rd_val[7:0] = thresh_reg;
      `CIV_STATUS_OFS >> 2: begin
        rd_val[NS-1:0] = pend_reg;
        rd_val[`CIV_STAT_BUSY_BIT] = qw_valid;
      end
      `CIV_COUNT_OFS >> 2: rd_val = count_reg;
      `CIV_LAST_OFS >> 2: rd_val = last_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CIV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `CIV_RESP_OKAY : `CIV_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: sim/civ_vector_gen_assertions.sv
// Port-level checker for the vector generator.
module civ_vector_gen_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire tx_underrun,
  input wire tx_in_packet,
  input wire tx_abort_req,
  input wire rx_frame_done,
  input wire rx_small_drop,
  input wire qw_valid,
  input wire qw_ready,
  input wire [2:0] qw_queue,
  input wire [31:0] qw_data
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_underrun_cause;
    tx_underrun && tx_in_packet;
  endsequence
  sequence s_tx_underrun_word;
    qw_valid && qw_data[28:27] == 2'b10 && qw_data[15];
  endsequence
  property p_queue_field;
    qw_valid |-> qw_queue == qw_data[26:24];
  endproperty
  a_queue_field: assert property (p_queue_field) else $error("queue field mismatch");
  property p_header;
    qw_valid |-> qw_data[31:29] == 3'b101 && qw_data[28:27] != 2'b11;
  endproperty
  a_header: assert property (p_header) else $error("bad header");
  property p_word_hold;
    qw_valid && !qw_ready |=> qw_valid && $stable(qw_data) && $stable(qw_queue);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word not held");
  property p_rx1_zero;
    qw_valid && qw_data[28:27] == 2'b00 |-> qw_data[23:16] == 8'h00 && qw_data[10:8] == 3'h0;
  endproperty
  a_rx1_zero: assert property (p_rx1_zero) else $error("rx1 gap not zero");
  property p_tx1_zero;
    qw_valid && qw_data[28:27] == 2'b10 |-> qw_data[23:16] == 8'h00 && qw_data[13:8] == 6'h00;
  endproperty
  a_tx1_zero: assert property (p_tx1_zero) else $error("tx1 gap not zero");
  property p_rx2_zero;
    qw_valid && qw_data[28:27] == 2'b01 |-> qw_data[23:22] == 2'b00;
  endproperty
  a_rx2_zero: assert property (p_rx2_zero) else $error("rx2 gap not zero");
  property p_abort_cause;
    tx_abort_req == $past(tx_underrun && tx_in_packet);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort request wrong");
  property p_underrun_vec;
    s_underrun_cause ##1 tx_abort_req |-> ##[0:40] s_tx_underrun_word;
  endproperty
  a_underrun_vec: assert property (p_underrun_vec) else $error("underrun vector missing");
  property p_small_cause;
    rx_small_drop |-> $past(rx_frame_done);
  endproperty
  a_small_cause: assert property (p_small_cause) else $error("small drop without frame");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("bresp not held");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata not held");
endmodule
bind civ_vector_gen civ_vector_gen_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .tx_underrun(tx_underrun), .tx_in_packet(tx_in_packet), .tx_abort_req(tx_abort_req),
  .rx_frame_done(rx_frame_done), .rx_small_drop(rx_small_drop), .qw_valid(qw_valid), .qw_ready(qw_ready),
  .qw_queue(qw_queue), .qw_data(qw_data));

// File: sim/civ_queue_host.sv
// Host-side interrupt queue model that takes vector words and can stall.
module civ_queue_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic qw_valid,
  input wire logic [2:0] qw_queue,
  input wire logic [31:0] qw_data,
  output logic qw_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [34:0] got[$];
  int n_acc;
  always @(posedge aclk) begin
    if (!aresetn) begin
      qw_ready <= 1'b0;
      n_acc <= 0;
    end else begin
      if (qw_valid && qw_ready) begin
        got.push_back({qw_queue, qw_data});
        n_acc <= n_acc + 1;
      end
      qw_ready <= !stall;
    end
  end
endmodule

// File: sim/tb_civ_vector_gen.sv
// Self-checking bench for the vector generator.
`include "civ_regs.vh"
module tb_civ_vector_gen;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_discard, fill_valid, rx_frame_done;
  logic rx_frame_host_req, rx_frame_abort, rx_frame_dma_ovf, rx_frame_crc_err, rx_frame_bad_len, rx_desc_done;
  logic rx_hold_discard, tx_underrun, tx_in_packet, tx_frame_sent, tx_abort_req, rx_small_drop, qw_valid, qw_ready;
  logic stall;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ch, fill_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, qw_data, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] tg;
  logic [15:0] ln;
  logic [2:0] qw_queue;
  int n_fail, compares, cyc;
  civ_vector_gen #(.LEN_W(16)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_discard(rx_discard), .rx_discard_channel_number(ch), .fill_valid(fill_valid), .fill_byte(fill_byte), .fill_channel_number(ch),
    .rx_frame_done(rx_frame_done), .rx_frame_channel_number(ch), .rx_frame_tag(tg), .rx_frame_len(ln),
    .rx_frame_host_req(rx_frame_host_req), .rx_frame_abort(rx_frame_abort), .rx_frame_dma_ovf(rx_frame_dma_ovf),
    .rx_frame_crc_err(rx_frame_crc_err), .rx_frame_bad_len(rx_frame_bad_len), .rx_desc_done(rx_desc_done),
    .rx_desc_channel_number(ch), .rx_desc_tag(tg), .rx_hold_discard(rx_hold_discard), .rx_hold_channel_number(ch), .rx_hold_tag(tg),
    .tx_underrun(tx_underrun), .tx_in_packet(tx_in_packet), .tx_frame_sent(tx_frame_sent), .tx_channel_number(ch),
    .tx_abort_req(tx_abort_req), .rx_small_drop(rx_small_drop), .qw_valid(qw_valid), .qw_ready(qw_ready),
    .qw_queue(qw_queue), .qw_data(qw_data));
  civ_queue_host host (.aclk(aclk), .aresetn(aresetn), .stall(stall), .qw_valid(qw_valid), .qw_queue(qw_queue),
    .qw_data(qw_data), .qw_ready(qw_ready));
  task automatic complete_run;
    begin
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    begin
      compares++;
      if (g !== e) begin
        n_fail++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Address and data go out together; each drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `CIV_RESP_OKAY);
    logic aw_done, w_done;
    begin
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) begin aw_done = 1'b1; s_axi_awvalid <= 1'b0; end
        if (s_axi_wvalid && s_axi_wready) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
      end while (!(aw_done && w_done));
      do @(posedge aclk); while (!s_axi_bvalid);
      chk("write response", 35'(er), 35'(s_axi_bresp));
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `CIV_RESP_OKAY);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk("read data", 35'(e), 35'(s_axi_rdata));
      chk("read response", 35'(er), 35'(s_axi_rresp));
    end
  endtask
  // Kinds: 0 discard, 1 fill, 2 frame, 3 desc done, 4 hold, 5 underrun in packet, 6 sent, 7 underrun idle.
  task automatic ev(input int k, input logic [7:0] c, input logic [5:0] t, input logic [15:0] l, input logic [4:0] f);
    begin
      ch <= c;
      tg <= t;
      ln <= l;
      fill_byte <= l[7:0];
      {rx_frame_host_req, rx_frame_abort, rx_frame_dma_ovf, rx_frame_crc_err, rx_frame_bad_len} <= f;
      tx_in_packet <= (k == 5);
      case (k)
        0: rx_discard <= 1'b1;
        1: fill_valid <= 1'b1;
        2: rx_frame_done <= 1'b1;
        3: rx_desc_done <= 1'b1;
        4: rx_hold_discard <= 1'b1;
        6: tx_frame_sent <= 1'b1;
        default: tx_underrun <= 1'b1;
      endcase
      @(posedge aclk);
      {rx_discard, fill_valid, rx_frame_done, rx_desc_done, rx_hold_discard, tx_underrun, tx_frame_sent} <= 7'h00;
      @(posedge aclk);
    end
  endtask
  task automatic exp_vec(input logic [2:0] q, input logic [31:0] w);
    int n;
    begin
      n = 0;
      while (host.got.size() == 0 && n < 100) begin
        @(posedge aclk);
        n++;
      end
      chk("vector", {q, w}, (host.got.size() > 0) ? host.got.pop_front() : 35'bx);
    end
  endtask
  task automatic no_vec;
    begin
      repeat (20) @(posedge aclk);
      chk("vector count", 35'd0, 35'(host.got.size()));
      host.got.delete();
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stall} = 6'h0A;
    {rx_discard, fill_valid, rx_frame_done, rx_desc_done, rx_hold_discard, tx_underrun, tx_frame_sent} = 7'h00;
    {rx_frame_host_req, rx_frame_abort, rx_frame_dma_ovf, rx_frame_crc_err, rx_frame_bad_len, tx_in_packet} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, ch, fill_byte, tg, ln, s_axi_wdata} = 78'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`CIV_CTRL_OFS, 32'h0000_0000);
    rd_chk(`CIV_SHORT_OFS, 32'h0000_0004);
    rd_chk(`CIV_MIN_OFS, 32'h0000_0004);
    rd_chk(`CIV_MAX_OFS, 32'h0000_0600);
    rd_chk(`CIV_THRESH_OFS, 32'h0000_0001);
    rd_chk(8'h40, 32'h0000_0000, `CIV_RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, `CIV_RESP_SLVERR);
    wr(`CIV_STATUS_OFS, 32'hFFFF_FFFF);
    rd_chk(`CIV_STATUS_OFS, 32'h0000_0000);
    wr(`CIV_CTRL_OFS, 32'h0000_0531);
    wr(`CIV_THRESH_OFS, 32'h0000_0002);
    ev(0, 8'h12, 6'h00, 16'h0000, 5'h00);
    exp_vec(3'h3, 32'hA300_8012);
    ev(2, 8'h21, 6'h2A, 16'h0064, 5'h1F);
    exp_vec(3'h3, 32'hAB2A_E721);
    ev(2, 8'h21, 6'h2A, 16'h0601, 5'h00);
    exp_vec(3'h3, 32'hAB2A_2821);
    ev(2, 8'h21, 6'h2A, 16'h0004, 5'h00);
    exp_vec(3'h3, 32'hA300_4021);
    exp_vec(3'h3, 32'hAB2A_2021);
    ev(2, 8'h21, 6'h2A, 16'h0003, 5'h00);
    no_vec;
    ev(2, 8'h21, 6'h2A, 16'h0003, 5'h00);
    exp_vec(3'h3, 32'hA300_0821);
    // The fill watcher's state after reset is open, so the first byte only primes it.
    ev(1, 8'h07, 6'h00, 16'h00FF, 5'h00);
    no_vec;
    ev(1, 8'h07, 6'h00, 16'h007E, 5'h00);
    exp_vec(3'h3, 32'hA300_2007);
    ev(1, 8'h07, 6'h00, 16'h00FF, 5'h00);
    exp_vec(3'h3, 32'hA300_1007);
    ev(3, 8'h30, 6'h05, 16'h0000, 5'h00);
    exp_vec(3'h3, 32'hAB05_8030);
    ev(4, 8'h40, 6'h11, 16'h0000, 5'h00);
    exp_vec(3'h3, 32'hAB11_1040);
    ev(4, 8'h40, 6'h11, 16'h0000, 5'h00);
    exp_vec(3'h3, 32'hAB11_5040);
    ev(6, 8'h05, 6'h00, 16'h0000, 5'h00);
    exp_vec(3'h5, 32'hB500_4005);
    ev(7, 8'h05, 6'h00, 16'h0000, 5'h00);
    exp_vec(3'h5, 32'hB500_8005);
    stall <= 1'b1;
    ev(0, 8'h12, 6'h00, 16'h0000, 5'h00);
    ev(5, 8'h05, 6'h00, 16'h0000, 5'h00);
    ev(6, 8'h05, 6'h00, 16'h0000, 5'h00);
    repeat (15) @(posedge aclk);
    stall <= 1'b0;
    exp_vec(3'h3, 32'hA300_8012);
    exp_vec(3'h5, 32'hB500_8005);
    exp_vec(3'h5, 32'hB500_4005);
    no_vec;
    rd_chk(`CIV_COUNT_OFS, 32'(host.n_acc));
    rd_chk(`CIV_LAST_OFS, 32'hB500_4005);
    wr(`CIV_CTRL_OFS, 32'h0000_0000);
    ev(0, 8'h12, 6'h00, 16'h0000, 5'h00);
    no_vec;
    complete_run;
  end
endmodule
